// ---- frf_pkg.sv ----
// constants and types of the function request facility
// Behaviour
// - in logical mode the control window map never changes, remap requests included
// - function requests enter only through the control window registers
// - every finished function updates status and, unless suppressed, pulses the interrupt request
// - a control bit suppresses interrupts for successful completions only
// - completion state shows whether a new request can be accepted
// - process index slot is qualified and locked when the opcode is written
// - one-byte opcode; writing it alone starts execution
// - up to seven 16-bit operands at rising addresses from the lowest slot
// - opcode alone sets operand count; higher slots are ignored
// - ordinal operands are unsigned 16-bit values
// - bit-field operands split into subfields chosen by the opcode
// - selector low subfield picks one of four segments, high subfield an index
// - selector resolution checks type, rights and bounds
// - completion state reads in-progress while a function executes
// - order: decode, fetch, operate, destination update, return value
// - finish writes success or fault and raises the interrupt request in the same cycle
// - a fault records extra fault information
// - request accesses are ordinary bus cycles without extra waits
// - return value low byte at lowest address; operands never altered
// - return value untouched by a successful function without return value
package frf_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_FSTATE = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_PROC = 8'h08;
   localparam logic [7:0] OFF_OPCODE = 8'h0c;
   localparam logic [7:0] OFF_RETVAL = 8'h10;
   localparam logic [7:0] OFF_FAULT = 8'h14;
   localparam logic [7:0] OFF_WIN4 = 8'h18;
   localparam logic [7:0] OFF_DEST = 8'h1c;
   localparam logic [7:0] OFF_SEGLIM = 8'h20;
   localparam logic [7:0] OFF_SEGATTR = 8'h24;
   localparam logic [2:0] OPND_REGION = 3'h2;
   localparam int OPND_SLOTS = 7;
   localparam int FS_COMP_LSB = 0;
   localparam int FS_LOCK_BIT = 2;
   localparam int FS_LOGIC_BIT = 3;
   localparam int CTRL_SUPP_BIT = 0;
   localparam int OPC_RET_BIT = 7;
   localparam int OPC_CLS_LSB = 4;
   localparam int OPC_DEST_BIT = 3;
   localparam int OPC_CNT_LSB = 0;
   localparam logic [2:0] CTRL_WIN = 3'h4;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] PROC_RST = 16'h0000;
   localparam logic [31:0] WIN4_RST = 32'h0000_0000;
   localparam logic [31:0] SEGLIM_RST = 32'hffff_ffff;
   localparam logic [15:0] SEGATTR_RST = 16'h3333;
   localparam logic [2:0] CL_SUM = 3'h0;
   localparam logic [2:0] CL_FIELD = 3'h1;
   localparam logic [2:0] CL_SELECT = 3'h2;
   localparam logic [2:0] CL_REMAP = 3'h3;
   localparam logic [2:0] CL_STORE = 3'h4;
   localparam logic [7:0] FC_NONE = 8'h00;
   localparam logic [7:0] FC_PROC = 8'h01;
   localparam logic [7:0] FC_OPCODE = 8'h02;
   localparam logic [7:0] FC_BOUND = 8'h03;
   localparam logic [7:0] FC_RIGHTS = 8'h04;
   localparam logic [7:0] FC_TYPE = 8'h05;
   localparam logic [7:0] FC_REMAP = 8'h06;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_DECODE = 3'h1, ST_FETCH = 3'h2, ST_OPERATE = 3'h3,
      ST_DEST = 3'h4, ST_RETVAL = 3'h5, ST_DONE = 3'h6
   } frf_state_e;
   typedef enum logic [1:0] {
      CS_READY = 2'h0, CS_BUSY = 2'h1, CS_OK = 2'h2, CS_FAULT = 2'h3
   } frf_comp_e;
endpackage

// ---- frf_opmem.sv ----
// operand slot store, one write port and two registered read ports
`timescale 1ns/1ns
module frf_opmem #(
   parameter int DEPTH = 7,
   parameter int WIDTH = 16,
   parameter int AW = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // bus read port
   input wire logic [AW-1:0] raddrA,
   output logic [WIDTH-1:0] rdataA,
   // execution read port
   input wire logic [AW-1:0] raddrB,
   output logic [WIDTH-1:0] rdataB
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we && (int'(waddr) < DEPTH)) begin
         mem[waddr] <= wdata;
      end
   end

   // out of range slots read as zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdataA <= '0;
         rdataB <= '0;
      end else begin
         rdataA <= (int'(raddrA) < DEPTH) ? mem[raddrA] : '0;
         rdataB <= (int'(raddrB) < DEPTH) ? mem[raddrB] : '0;
      end
   end
endmodule

// ---- frf_top.sv ----
// function request facility: apb request area and serial function executor
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
module frf_top #(
   parameter int PROC_COUNT = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [frf_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mode and host notification
   input wire logic logicalMode,
   output logic irqReq
);
   import frf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // request area registers
   logic [31:0] ctrl;
   logic [15:0] procIdx;
   logic [31:0] segLim;
   logic [15:0] segAttr;
   logic [31:0] retVal;
   logic [31:0] faultInfo;
   logic [31:0] win4Map;
   logic [31:0] destVal;
   frf_comp_e compState;
   logic locked;

   logic setupPh;
   logic wrAcc;
   logic busy;
   logic opndHit;
   logic [2:0] opndIdx;
   logic mapped;
   logic opcWr;
   logic opWe;

   assign busy = (compState == CS_BUSY);
   assign setupPh = psel && !penable;
   assign wrAcc = psel && penable && pwrite;
   assign opndIdx = paddr[4:2];
   assign opndHit = (paddr[7:5] == OPND_REGION) && (int'(opndIdx) < OPND_SLOTS) && (paddr[1:0] == 2'h0);

   always_comb begin
      case (paddr)
         OFF_FSTATE, OFF_CTRL, OFF_PROC, OFF_OPCODE, OFF_RETVAL, OFF_FAULT, OFF_WIN4, OFF_DEST,
         OFF_SEGLIM, OFF_SEGATTR: mapped = 1'b1;
         default: mapped = opndHit;
      endcase
   end

   // zero wait states; request area cycles are plain bus cycles
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // opcode byte lane strobed at its offset starts a function
   assign opcWr = wrAcc && (paddr == OFF_OPCODE) && pstrb[0] && !busy;
   // operands are frozen while a function runs
   assign opWe = wrAcc && opndHit && (pstrb[1:0] != 2'h0) && !busy;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RST;
         procIdx <= PROC_RST;
         segLim <= SEGLIM_RST;
         segAttr <= SEGATTR_RST;
      end else if (wrAcc && (pstrb != 4'h0)) begin
         if (paddr == OFF_CTRL) begin
            ctrl <= pwdata;
         end
         // request slots ignored while busy, overlap gives no defined result
         if (!busy) begin
            if (paddr == OFF_PROC) begin
               procIdx <= pwdata[15:0];
            end
            if (paddr == OFF_SEGLIM) begin
               segLim <= pwdata;
            end
            if (paddr == OFF_SEGATTR) begin
               segAttr <= pwdata[15:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup phase
   logic [31:0] regRd;
   logic [31:0] regRdQ;
   logic opRdQ;
   logic [15:0] memRdA;
   logic [15:0] memRdB;
   logic [2:0] fetchCnt;

   always_comb begin
      case (paddr)
         OFF_FSTATE: regRd = {28'h0, logicalMode, locked, compState};
         OFF_CTRL: regRd = ctrl;
         OFF_PROC: regRd = {16'h0, procIdx};
         OFF_RETVAL: regRd = retVal;
         OFF_FAULT: regRd = faultInfo;
         OFF_WIN4: regRd = win4Map;
         OFF_DEST: regRd = destVal;
         OFF_SEGLIM: regRd = segLim;
         OFF_SEGATTR: regRd = {16'h0, segAttr};
         default: regRd = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdQ <= 32'h0;
         opRdQ <= 1'b0;
      end else if (setupPh) begin
         regRdQ <= regRd;
         opRdQ <= opndHit;
      end
   end

   assign prdata = opRdQ ? {16'h0, memRdA} : regRdQ;

   frf_opmem #(.DEPTH(OPND_SLOTS), .WIDTH(16), .AW(3)) uOpmem (
      .clk(clk),
      .rst_n(rst_n),
      .we(opWe),
      .waddr(opndIdx),
      .wdata(pwdata[15:0]),
      .raddrA(opndIdx),
      .rdataA(memRdA),
      .raddrB(fetchCnt),
      .rdataB(memRdB)
   );

   ////////////////////////////////////////////////////////////////////////////
   // function executor
   frf_state_e state;
   logic [7:0] opcode;
   logic fetchPh;
   logic [31:0] acc;
   logic [15:0] op0;
   logic [15:0] op1;
   logic [31:0] result;
   logic [7:0] faultCode;
   logic [2:0] opCnt;
   logic [2:0] opCls;
   logic [1:0] selSeg;
   logic [13:0] selIdx;
   logic [7:0] selLim;
   logic [3:0] selAttr;
   logic [31:0] fieldMask;
   logic [31:0] next_result;
   logic [7:0] next_fault;

   assign opCnt = opcode[OPC_CNT_LSB +: 3];
   assign opCls = opcode[OPC_CLS_LSB +: 3];
   assign selSeg = op0[1:0];
   assign selIdx = op0[15:2];
   assign selLim = segLim[8*selSeg +: 8];
   assign selAttr = segAttr[4*selSeg +: 4];
   // width subfield holds width minus one
   assign fieldMask = (32'h2 << op0[7:4]) - 32'h1;

   always_comb begin
      next_result = 32'h0;
      next_fault = FC_NONE;
      case (opCls)
         CL_SUM: next_result = acc;
         CL_FIELD: next_result = ({16'h0, op1} >> op0[3:0]) & fieldMask;
         CL_SELECT: begin
            if ((op1[1:0] & ~selAttr[1:0]) != 2'h0) begin
               next_fault = FC_RIGHTS;
            end else if (op1[3:2] != selAttr[3:2]) begin
               next_fault = FC_TYPE;
            end else if ({2'h0, selIdx} > {8'h0, selLim}) begin
               next_fault = FC_BOUND;
            end
            next_result = {14'h0, selSeg, 2'h0, selIdx};
         end
         CL_REMAP: begin
            if ((op0[2:0] == CTRL_WIN) && logicalMode) begin
               next_fault = FC_REMAP;
            end
         end
         CL_STORE: next_result = {op1, op0};
         default: next_fault = FC_OPCODE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         opcode <= 8'h0;
         fetchCnt <= 3'h0;
         fetchPh <= 1'b0;
         acc <= 32'h0;
         op0 <= 16'h0;
         op1 <= 16'h0;
         result <= 32'h0;
         faultCode <= FC_NONE;
         compState <= CS_READY;
         locked <= 1'b0;
         retVal <= 32'h0;
         faultInfo <= 32'h0;
         win4Map <= WIN4_RST;
         destVal <= 32'h0;
         irqReq <= 1'b0;
      end else begin
         irqReq <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (opcWr) begin
                  opcode <= pwdata[7:0];
                  compState <= CS_BUSY;
                  fetchCnt <= 3'h0;
                  fetchPh <= 1'b0;
                  acc <= 32'h0;
                  faultCode <= FC_NONE;
                  state <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               if (int'(procIdx) >= PROC_COUNT) begin
                  faultCode <= FC_PROC;
                  state <= ST_DONE;
               end else if (opCls > CL_STORE) begin
                  faultCode <= FC_OPCODE;
                  state <= ST_DONE;
               end else begin
                  locked <= 1'b1;
                  state <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               // one slot per two cycles: address, then registered data
               if (fetchCnt == opCnt) begin
                  state <= ST_OPERATE;
               end else if (!fetchPh) begin
                  fetchPh <= 1'b1;
               end else begin
                  acc <= acc + {16'h0, memRdB};
                  if (fetchCnt == 3'h0) begin
                     op0 <= memRdB;
                  end
                  if (fetchCnt == 3'h1) begin
                     op1 <= memRdB;
                  end
                  fetchCnt <= fetchCnt + 3'h1;
                  fetchPh <= 1'b0;
               end
            end
            ST_OPERATE: begin
               result <= next_result;
               faultCode <= next_fault;
               state <= (next_fault != FC_NONE) ? ST_DONE : ST_DEST;
            end
            ST_DEST: begin
               if (opcode[OPC_DEST_BIT]) begin
                  destVal <= result;
               end
               // only the control window map is stored; in logical mode its remap already faulted in operate
               if ((opCls == CL_REMAP) && (op0[2:0] == CTRL_WIN)) begin
                  win4Map <= {16'h0, op1};
               end
               state <= ST_RETVAL;
            end
            ST_RETVAL: begin
               if (opcode[OPC_RET_BIT]) begin
                  retVal <= result;
               end
               state <= ST_DONE;
            end
            ST_DONE: begin
               locked <= 1'b0;
               if (faultCode != FC_NONE) begin
                  compState <= CS_FAULT;
                  faultInfo <= {8'h0, procIdx[7:0], opcode, faultCode};
                  irqReq <= 1'b1;
               end else begin
                  compState <= CS_OK;
                  irqReq <= !ctrl[CTRL_SUPP_BIT];
               end
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_startBusy;
      opcWr |=> (compState == CS_BUSY) && (state == ST_DECODE);
   endproperty
   a_startBusy: assert property (p_startBusy) else $error("opcode write did not start");

   property p_busyHeld;
      (state != ST_IDLE) |-> (compState == CS_BUSY) || (state == ST_DONE && $past(state) == ST_DONE);
   endproperty
   a_busyHeld: assert property (p_busyHeld) else $error("busy not shown during execution");

   property p_irqAfterDone;
      (state == ST_DONE) |=> (compState != CS_BUSY) && (irqReq || (compState == CS_OK && ctrl[CTRL_SUPP_BIT]));
   endproperty
   a_irqAfterDone: assert property (p_irqAfterDone) else $error("completion without interrupt");

   property p_suppress;
      irqReq && ctrl[CTRL_SUPP_BIT] && !$past(wrAcc) |-> compState == CS_FAULT;
   endproperty
   a_suppress: assert property (p_suppress) else $error("suppressed success raised interrupt");

   property p_win4Fixed;
      logicalMode && $past(logicalMode) |-> $stable(win4Map);
   endproperty
   a_win4Fixed: assert property (p_win4Fixed) else $error("control window remapped in logical mode");

   property p_opsFrozen;
      busy |-> !opWe;
   endproperty
   a_opsFrozen: assert property (p_opsFrozen) else $error("operand written while busy");

   property p_retKept;
      (state == ST_RETVAL) && !opcode[OPC_RET_BIT] |=> $stable(retVal);
   endproperty
   a_retKept: assert property (p_retKept) else $error("return value altered without result");

   property p_fetchCount;
      (state == ST_FETCH) ##1 (state == ST_OPERATE) |-> fetchCnt == opCnt;
   endproperty
   a_fetchCount: assert property (p_fetchCount) else $error("wrong operand count fetched");

   property p_order;
      (state == ST_OPERATE) |-> $past(state) == ST_FETCH;
   endproperty
   a_order: assert property (p_order) else $error("operate entered out of order");

   property p_badProc;
      opcWr && (int'(procIdx) >= PROC_COUNT) |-> ##3 (compState == CS_FAULT) && irqReq;
   endproperty
   a_badProc: assert property (p_badProc) else $error("bad process index not faulted");

   property p_faultRecord;
      (state == ST_DONE) && (faultCode != FC_NONE) |=> faultInfo[7:0] == $past(faultCode);
   endproperty
   a_faultRecord: assert property (p_faultRecord) else $error("fault not recorded");

   property p_finishWithin;
      opcWr |-> ##[4:24] (compState != CS_BUSY);
   endproperty
   a_finishWithin: assert property (p_finishWithin) else $error("function did not finish");

   c_success: cover property ((state == ST_DONE) ##1 (compState == CS_OK) && irqReq);
   c_fault: cover property ((state == ST_DONE) ##1 (compState == CS_FAULT));
   c_suppressed: cover property ((state == ST_DONE) ##1 (compState == CS_OK) && !irqReq);
   c_sevenOps: cover property ((state == ST_OPERATE) && (opCnt == 3'h7));
endmodule

// ---- frf_host_model.sv ----
// host-side apb master model that issues requests to the request area
`timescale 1ns/1ns
module frf_host_model (
   // clock
   input wire logic clk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [frf_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import frf_pkg::*;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // callers serialise requests and put operands in place before the opcode
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] rd, output logic err, output logic ok);
      ok = 1'b0;
      rd = '0;
      err = 1'b0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      for (int i = 0; i < 16 && !ok; i++) begin
         @(posedge clk);
         if (pready === 1'b1) begin
            ok = 1'b1;
            rd = prdata;
            err = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines change so a stale value never passes for data
      paddr <= ~a;
      pwdata <= ~d;
      pstrb <= '0;
   endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the function request facility
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("BAD %s expected %h seen %h", n, e, g); \
   end \
end
module tb_top;
   import frf_pkg::*;
   logic clk, rst_n, logicalMode, psel, penable, pwrite, pready, pslverr, irqReq, er;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [3:0] pstrb;
   int bad_count, check_count;
   frf_top #(.PROC_COUNT(16)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .logicalMode(logicalMode), .irqReq(irqReq));
   frf_host_model hostU (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic [31:0] x;
      logic ok;
      hostU.xfer(1'b1, a, d, s, x, er, ok);
      if (!ok) begin
         bad_count++;
         results();
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic ok;
      hostU.xfer(1'b0, a, 32'h0, 4'h0, v, er, ok);
      if (!ok) begin
         bad_count++;
         results();
      end
   endtask
   // opcode write, then bounded watch for the interrupt pulse; cyc 0 means none expected
   task automatic fn(input logic [7:0] opc, input logic [3:0] s, input int cyc, input logic [1:0] comp);
      int k;
      k = 0;
      wr(OFF_OPCODE, {24'h0, opc}, s);
      for (int i = 1; i <= 40 && k == 0; i++) begin
         @(negedge clk);
         if (irqReq === 1'b1) k = i;
      end
      if (cyc != 0 && k == 0) begin
         bad_count++;
         results();
      end
      `CHK("irq delay", (cyc == 0) ? 0 : cyc + 1, k)
      if (k != 0) begin
         @(negedge clk);
         `CHK("irq pulse", 1'b0, irqReq)
      end
      rd(OFF_FSTATE, rv);
      `CHK("completion", comp, rv[1:0])
   endtask
   task automatic ops(input logic [15:0] a, input logic [15:0] b);
      wr(8'h40, {16'h0, a});
      wr(8'h44, {16'h0, b});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset_map;
      rd(OFF_FSTATE, rv);
      `CHK("fstate", 32'h0000_0008, rv)
      `CHK("mapped err", 1'b0, er)
      rd(OFF_SEGLIM, rv);
      `CHK("seglim", SEGLIM_RST, rv)
      rd(OFF_SEGATTR, rv);
      `CHK("segattr", {16'h0, SEGATTR_RST}, rv)
      rd(OFF_WIN4, rv);
      `CHK("win4", WIN4_RST, rv)
      rd(8'h30, rv);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rv)
      rd(8'h06, rv);
      `CHK("unaligned err", 1'b1, er)
   endtask
   task t_sum_busy;
      ops(16'h0005, 16'h0007);
      wr(8'h48, 32'h9);
      wr(8'h4c, 32'hffff);
      wr(OFF_PROC, 32'h2);
      fn(8'h8b, 4'h1, 12, CS_OK);
      rd(OFF_RETVAL, rv);
      `CHK("sum", 32'h15, rv)
      rd(OFF_DEST, rv);
      `CHK("dest", 32'h15, rv)
      rd(8'h40, rv);
      `CHK("operand kept", 32'h5, rv)
      wr(OFF_OPCODE, 32'h03, 4'h1);
      rd(OFF_FSTATE, rv);
      `CHK("busy", CS_BUSY, rv[1:0])
      wr(8'h40, 32'h77);
      fn(8'hc2, 4'h1, 3, CS_OK);
      rd(OFF_RETVAL, rv);
      `CHK("retval untouched", 32'h15, rv)
      rd(8'h40, rv);
      `CHK("frozen operand", 32'h5, rv)
      wr(8'h50, 32'h1);
      wr(8'h54, 32'h2);
      wr(8'h58, 32'h3);
      fn(8'h87, 4'h1, 20, CS_OK);
      rd(OFF_RETVAL, rv);
      `CHK("sum of seven", 32'h0001_001a, rv)
   endtask
   task t_field_store;
      ops(16'h0034, 16'hbeef);
      fn(8'h92, 4'h1, 10, CS_OK);
      rd(OFF_RETVAL, rv);
      `CHK("field", 32'he, rv)
      ops(16'h3344, 16'h1122);
      fn(8'hc2, 4'h1, 10, CS_OK);
      rd(OFF_RETVAL, rv);
      `CHK("store", 32'h1122_3344, rv)
   endtask
   task automatic t_select;
      logic [31:0] lim [4] = '{32'h1000, 32'h0, 32'h1000, 32'h1000};
      logic [15:0] attr [4] = '{16'h3333, 16'h3333, 16'h3303, 16'h3333};
      logic [15:0] need [4] = '{16'h0, 16'h0, 16'h1, 16'h4};
      logic [7:0] code [4] = '{FC_NONE, FC_BOUND, FC_RIGHTS, FC_TYPE};
      for (int i = 0; i < 4; i++) begin
         wr(OFF_SEGLIM, lim[i]);
         wr(OFF_SEGATTR, {16'h0, attr[i]});
         ops(16'h000d, need[i]);
         if (i == 0) begin
            fn(8'ha2, 4'h1, 10, CS_OK);
            rd(OFF_RETVAL, rv);
            `CHK("selector", 32'h0001_0003, rv)
         end else begin
            fn(8'ha2, 4'h1, 8, CS_FAULT);
            rd(OFF_FAULT, rv);
            `CHK("select fault", {16'h0002, 8'ha2, code[i]}, rv)
         end
      end
   endtask
   task t_suppress;
      wr(OFF_CTRL, 32'h1);
      fn(8'h00, 4'h1, 0, CS_OK);
      wr(OFF_PROC, 32'h10);
      fn(8'h00, 4'h1, 2, CS_FAULT);
      rd(OFF_FAULT, rv);
      `CHK("proc fault", 32'h0010_0001, rv)
      wr(OFF_PROC, 32'h2);
      fn(8'h50, 4'h1, 2, CS_FAULT);
      rd(OFF_FAULT, rv);
      `CHK("class fault", 32'h0002_5002, rv)
      wr(OFF_CTRL, 32'h0);
   endtask
   task t_remap_strobe;
      ops(16'h0004, 16'h00a5);
      fn(8'h32, 4'h1, 8, CS_FAULT);
      rd(OFF_FAULT, rv);
      `CHK("remap fault", 32'h0002_3206, rv)
      rd(OFF_WIN4, rv);
      `CHK("win4 locked", WIN4_RST, rv)
      @(posedge clk);
      logicalMode <= 1'b0;
      fn(8'h32, 4'h1, 10, CS_OK);
      rd(OFF_WIN4, rv);
      `CHK("win4 phys", 32'h0000_00a5, rv)
      logicalMode <= 1'b1;
      fn(8'h00, 4'h2, 0, CS_OK);
      fn(8'h00, 4'h1, 6, CS_OK);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      logicalMode = 1'b1;
      bad_count = 0;
      check_count = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_map();
      t_sum_busy();
      t_field_store();
      t_select();
      t_suppress();
      t_remap_strobe();
      results();
   end
endmodule
